// ### src/vic_cmd_unit.sv
// Overview of operation
// RQ1: status bit 0 reads 1 while the fast request line is asserted.
// RQ2: status bit 1 reads 1 while the normal request line is asserted.
// RQ3: enable command ones set the matching mask bits; zeros do nothing.
// RQ4: disable command ones clear the matching mask bits; zeros do nothing.
// RQ5: clear command ones clear matching pending bits; zeros do nothing. Level-triggered sources ignore it here and follow their line.
// RQ6: set command ones force matching sources pending; zeros do nothing.
// RQ7: bits 0-8 and 16-18 map sources; all other bits are ignored.
// RQ8: any write to end-of-service command ends the current interrupt.
// RQ9: spurious handler address is 32-bit read/write, resets to zero.
// RQ10: normal vector read makes highest pending source current, adopts its level.
// RQ11: only a normal vector read de-asserts the normal request line.
// RQ12: normal vector read auto-clears the selected source if edge triggered.
// RQ13: normal vector read pushes the new level onto the level stack.
// RQ14: normal vector read returns the selected source's handler address.
// RQ15: pending source above current level re-asserts the normal request line.
// RQ16: handler removes a level-sensitive request before finishing service.
// RQ17: handler masks the core then writes end-of-service before returning.
// RQ18: end-of-service pops the stack, restoring the previous level if any.
// RQ19: after a pop, a pending source above restored level re-asserts the line.
// RQ20: fast vector read clears source 0 only if edge triggered.
// RQ21: handler clears a level-sensitive fast request itself.
// RQ22: fast vector read returns source 0's handler address.
// RQ23: non-fast sources have priority 0 lowest to 7 highest; fast ignores it.
// RQ24: normal vector read returns zero when no current interrupt exists.
// RQ25: external trigger codes 00 low,01 fall,10 high,11 rise; internal use bit 0.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module vic_cmd_unit
    import vic_cmd_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // source lines and core request lines
    input wire logic [31:0] src_line_i,
    output logic fast_request_line_n_o,
    output logic normal_request_line_n_o
);
    src_mode_t mode_reg [32];
    logic [31:0] vector_reg [32];
    logic [31:0] pend_reg, pend_next, mask_reg, act_q_reg, act, set_v, clr_v;
    logic [31:0] spurious_reg, rdata;
    stack_entry_t stack_reg [STACK_DEPTH];
    logic [3:0] depth_reg;
    logic ready_reg, err_reg, fiq_reg, irq_reg;
    logic acc, wr, rd, hit, ivr_rd, fvr_rd, eoi_wr, want;
    logic cand_valid;
    logic [4:0] cand_id;
    logic [2:0] cand_prio, cur_prio;
    logic [4:0] cur_id;
    logic [11:0] word_off;
    logic [4:0] idx;

    // the access cycle commits every effect; pready follows one cycle later
    assign acc = psel_i & penable_i & ~ready_reg;
    assign wr = acc & pwrite_i;
    assign rd = acc & ~pwrite_i;
    assign idx = paddr_i[6:2];
    assign word_off = {paddr_i[11:2], 2'b00};
    assign ivr_rd = rd & (word_off == NORMAL_VECTOR_READ);
    assign fvr_rd = rd & (word_off == FAST_VECTOR_READ);
    assign eoi_wr = wr & (word_off == END_OF_SERVICE_COMMAND); // RQ8
    assign pready_o = ready_reg;
    assign pslverr_o = err_reg;
    assign cur_prio = (depth_reg != 4'h0) ? stack_reg[3'(depth_reg - 4'h1)].prio : 3'h0;
    assign cur_id = (depth_reg != 4'h0) ? stack_reg[3'(depth_reg - 4'h1)].id : 5'h00;

    // highest priority enabled pending source, lowest index wins a tie
    always_comb
    begin
        cand_valid = 1'b0;
        cand_id = 5'h00;
        cand_prio = 3'h0;
        for (int i = 1; i < 32; i++)
        begin
            if (pend_reg[i] && mask_reg[i] && VALID_SRC[i] &&
                (!cand_valid || mode_reg[i].prio > cand_prio)) // RQ23
            begin
                cand_valid = 1'b1;
                cand_id = 5'(i);
                cand_prio = mode_reg[i].prio;
            end
        end
    end

    // a source above the current level, or any with nothing in service
    assign want = cand_valid & ((depth_reg == 4'h0) | (cand_prio > cur_prio)); // RQ15 RQ19

    genvar g;
    generate
        for (g = 0; g < 32; g++)
        begin : g_src
            if (VALID_SRC[g])
            begin : g_on
                // external lines pick their sense; internal ones are active high
                assign act[g] = EXT_SRC[g] ?
                    (src_line_i[g] ~^ mode_reg[g].trig[1]) : src_line_i[g]; // RQ25
                assign clr_v[g] = (wr & (word_off == PENDING_CLEAR_COMMAND) & pwdata_i[g]) // RQ5
                    | (ivr_rd & cand_valid & (cand_id == 5'(g)) & mode_reg[g].trig[0]) // RQ12
                    | (fvr_rd & (g == FAST_SRC) & mode_reg[g].trig[0]); // RQ20
                assign set_v[g] = (wr & (word_off == PENDING_SET_COMMAND) & pwdata_i[g]) // RQ6
                    | (mode_reg[g].trig[0] & act[g] & ~act_q_reg[g]);
                // set beats clear; level sources follow their line
                assign pend_next[g] = set_v[g] |
                    (mode_reg[g].trig[0] ? (pend_reg[g] & ~clr_v[g]) : act[g]);
            end
            else
            begin : g_off
                assign act[g] = 1'b0; // RQ7
                assign clr_v[g] = 1'b0;
                assign set_v[g] = 1'b0;
                assign pend_next[g] = 1'b0;
            end

            always_ff @(posedge core_clk_i)
            begin
                if (!rstn_i)
                begin
                    mode_reg[g] <= '0;
                    vector_reg[g] <= 32'h0000_0000;
                end
                else if (wr && idx == 5'(g))
                begin
                    if (word_off[11:7] == MODE_BASE[11:7] && VALID_SRC[g])
                    begin
                        mode_reg[g].trig <= pwdata_i[TRIG_LSB +: 2] &
                            (EXT_SRC[g] ? 2'h3 : 2'h1);
                        mode_reg[g].prio <= pwdata_i[PRIO_LSB +: 3];
                    end
                    if (word_off[11:7] == VECT_BASE[11:7])
                    begin
                        vector_reg[g] <= pwdata_i;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            pend_reg <= 32'h0000_0000;
            act_q_reg <= 32'h0000_0000;
        end
        else
        begin
            pend_reg <= pend_next;
            act_q_reg <= act;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            mask_reg <= 32'h0000_0000;
        end
        else if (wr && word_off == SOURCE_ENABLE_COMMAND)
        begin
            mask_reg <= mask_reg | (pwdata_i & VALID_SRC); // RQ3
        end
        else if (wr && word_off == SOURCE_DISABLE_COMMAND)
        begin
            mask_reg <= mask_reg & ~pwdata_i; // RQ4
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            spurious_reg <= SPURIOUS_RESET;
        end
        else if (wr && word_off == SPURIOUS_HANDLER_ADDRESS)
        begin
            spurious_reg <= pwdata_i; // RQ9
        end
    end

    // level stack: a full stack refuses further pushes
    // deeper nesting still answers the read, but that level is lost
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            depth_reg <= 4'h0;
        end
        else if (ivr_rd && cand_valid && depth_reg != 4'(STACK_DEPTH))
        begin
            stack_reg[depth_reg[2:0]] <= '{prio: cand_prio, id: cand_id}; // RQ10 RQ13
            depth_reg <= depth_reg + 4'h1;
        end
        else if (eoi_wr && depth_reg != 4'h0)
        begin
            depth_reg <= depth_reg - 4'h1; // RQ18
        end
    end

    // request lines; normal falls only on a vector read
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            irq_reg <= 1'b0;
            fiq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= ivr_rd ? 1'b0 : (irq_reg | want); // RQ11 RQ15 RQ19
            fiq_reg <= pend_reg[FAST_SRC] & mask_reg[FAST_SRC];
        end
    end
    assign fast_request_line_n_o = ~fiq_reg;
    assign normal_request_line_n_o = ~irq_reg;

    always_comb
    begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        if (word_off[11:7] == MODE_BASE[11:7])
        begin
            rdata = {25'h0000000, mode_reg[idx].trig, 2'h0, mode_reg[idx].prio};
        end
        else if (word_off[11:7] == VECT_BASE[11:7])
        begin
            rdata = vector_reg[idx];
        end
        else
        begin
            unique case (word_off)
                NORMAL_VECTOR_READ:
                    rdata = cand_valid ? vector_reg[cand_id] : // RQ14
                        ((depth_reg != 4'h0) ? vector_reg[cur_id] : 32'h0000_0000); // RQ24
                FAST_VECTOR_READ: rdata = vector_reg[FAST_SRC]; // RQ22
                CURRENT_ID: rdata = {27'h0000000, cur_id};
                PENDING_STATUS: rdata = pend_reg;
                MASK_STATUS: rdata = mask_reg;
                CORE_REQUEST_LINE_STATUS:
                    rdata = {30'h00000000, irq_reg, fiq_reg}; // RQ1 RQ2
                SPURIOUS_HANDLER_ADDRESS: rdata = spurious_reg;
                SOURCE_ENABLE_COMMAND, SOURCE_DISABLE_COMMAND, PENDING_CLEAR_COMMAND,
                PENDING_SET_COMMAND, END_OF_SERVICE_COMMAND: rdata = 32'h0000_0000;
                default: hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else
        begin
            ready_reg <= acc;
            err_reg <= acc & ~hit;
            if (rd)
            begin
                prdata_o <= rdata;
            end
        end
    end

    property p_status_lines;
        @(posedge core_clk_i) disable iff (!rstn_i)
        rd && word_off == CORE_REQUEST_LINE_STATUS |=>
            prdata_o[1] == !$past(normal_request_line_n_o) &&
            prdata_o[0] == !$past(fast_request_line_n_o);
    endproperty
    a_status_lines: assert property (p_status_lines) else $error("status bits wrong"); // RQ1
    property p_enable;
        @(posedge core_clk_i) disable iff (!rstn_i)
        wr && word_off == SOURCE_ENABLE_COMMAND && pwdata_i[3] |=> mask_reg[3];
    endproperty
    a_enable: assert property (p_enable) else $error("enable missed"); // RQ3
    property p_disable;
        @(posedge core_clk_i) disable iff (!rstn_i)
        wr && word_off == SOURCE_DISABLE_COMMAND |=> (mask_reg & $past(pwdata_i)) == 32'h0;
    endproperty
    a_disable: assert property (p_disable) else $error("disable missed"); // RQ4
    property p_set;
        @(posedge core_clk_i) disable iff (!rstn_i)
        wr && word_off == PENDING_SET_COMMAND |=>
            (pend_reg & $past(pwdata_i) & VALID_SRC) == ($past(pwdata_i) & VALID_SRC);
    endproperty
    a_set: assert property (p_set) else $error("set missed"); // RQ6
    property p_spurious;
        @(posedge core_clk_i) disable iff (!rstn_i)
        wr && word_off == SPURIOUS_HANDLER_ADDRESS |=> spurious_reg == $past(pwdata_i);
    endproperty
    a_spurious: assert property (p_spurious) else $error("spurious not stored"); // RQ9
    property p_ivr_drop;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ivr_rd |=> normal_request_line_n_o;
    endproperty
    a_ivr_drop: assert property (p_ivr_drop) else $error("normal line held"); // RQ11
    property p_push;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ivr_rd && cand_valid && depth_reg < 4'h8 |=>
            depth_reg == $past(depth_reg) + 4'h1 && cur_prio == $past(cand_prio);
    endproperty
    a_push: assert property (p_push) else $error("level not pushed"); // RQ13
    property p_pop;
        @(posedge core_clk_i) disable iff (!rstn_i)
        eoi_wr && depth_reg != 4'h0 |=> depth_reg == $past(depth_reg) - 4'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("level not popped"); // RQ18
    property p_reassert;
        @(posedge core_clk_i) disable iff (!rstn_i)
        want && !ivr_rd |=> !normal_request_line_n_o;
    endproperty
    a_reassert: assert property (p_reassert) else $error("line not raised"); // RQ15
    property p_fast_clear;
        @(posedge core_clk_i) disable iff (!rstn_i)
        fvr_rd && mode_reg[0].trig[0] && !set_v[0] |=> !pend_reg[0] ##1 fast_request_line_n_o;
    endproperty
    a_fast_clear: assert property (p_fast_clear) else $error("fast not cleared"); // RQ20
    // vector reads, the request line between reads, and unused source bits
    property p_edge_clear;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ivr_rd && cand_valid && mode_reg[cand_id].trig[0] && !set_v[cand_id] |=>
            !pend_reg[$past(cand_id)];
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge source kept"); // RQ12
    property p_level_fast;
        @(posedge core_clk_i) disable iff (!rstn_i)
        fvr_rd && !mode_reg[FAST_SRC].trig[0] && act[FAST_SRC] |=> pend_reg[FAST_SRC];
    endproperty
    a_level_fast: assert property (p_level_fast) else $error("level fast cleared"); // RQ20
    property p_fast_vector;
        @(posedge core_clk_i) disable iff (!rstn_i)
        fvr_rd |=> prdata_o == vector_reg[FAST_SRC];
    endproperty
    a_fast_vector: assert property (p_fast_vector) else $error("fast vector wrong"); // RQ22
    property p_empty_vector;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ivr_rd && !cand_valid && depth_reg == 4'h0 |=> prdata_o == 32'h0000_0000;
    endproperty
    a_empty_vector: assert property (p_empty_vector) else $error("empty read not zero"); // RQ24
    property p_irq_hold;
        @(posedge core_clk_i) disable iff (!rstn_i)
        !normal_request_line_n_o && !ivr_rd |=> !normal_request_line_n_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("normal line dropped"); // RQ11
    property p_unused_bits;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ((mask_reg | pend_reg) & ~VALID_SRC) == 32'h0000_0000;
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("unused bit set"); // RQ7
    c_nested: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        ivr_rd && depth_reg == 4'h1 && cand_valid);
    c_eoi: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        eoi_wr ##1 !normal_request_line_n_o);
    c_fast: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        !fast_request_line_n_o ##[1:20] fvr_rd);
    c_level_fast: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        fvr_rd && !mode_reg[FAST_SRC].trig[0]);
    c_empty_read: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        ivr_rd && !cand_valid && depth_reg == 4'h0);
endmodule // vic_cmd_unit
`default_nettype wire

// ### common/vic_cmd_pkg.sv
`default_nettype none
package vic_cmd_pkg;
    // register byte offsets
    localparam logic [11:0] MODE_BASE = 12'h000;
    localparam logic [11:0] VECT_BASE = 12'h080;
    localparam logic [11:0] NORMAL_VECTOR_READ = 12'h100;
    localparam logic [11:0] FAST_VECTOR_READ = 12'h104;
    localparam logic [11:0] CURRENT_ID = 12'h108;
    localparam logic [11:0] PENDING_STATUS = 12'h10c;
    localparam logic [11:0] MASK_STATUS = 12'h110;
    localparam logic [11:0] CORE_REQUEST_LINE_STATUS = 12'h114;
    localparam logic [11:0] SOURCE_ENABLE_COMMAND = 12'h120;
    localparam logic [11:0] SOURCE_DISABLE_COMMAND = 12'h124;
    localparam logic [11:0] PENDING_CLEAR_COMMAND = 12'h128;
    localparam logic [11:0] PENDING_SET_COMMAND = 12'h12c;
    localparam logic [11:0] END_OF_SERVICE_COMMAND = 12'h130;
    localparam logic [11:0] SPURIOUS_HANDLER_ADDRESS = 12'h134;
    // status bit positions
    localparam int FAST_LINE_BIT = 0;
    localparam int NORMAL_LINE_BIT = 1;
    // mode register fields
    localparam int PRIO_LSB = 0;
    localparam int TRIG_LSB = 5;
    // implemented sources and those with a two-bit trigger code
    localparam logic [31:0] VALID_SRC = 32'h0007_01ff;
    localparam logic [31:0] EXT_SRC = 32'h0007_0001;
    localparam int FAST_SRC = 0;
    localparam int STACK_DEPTH = 8;
    localparam logic [31:0] SPURIOUS_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [1:0] trig;
        logic [2:0] prio;
    } src_mode_t;

    typedef struct packed {
        logic [2:0] prio;
        logic [4:0] id;
    } stack_entry_t;
endpackage
`default_nettype wire

// ### tb/core_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_side_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // level requests the handler has not yet removed
    input wire logic [31:0] level_req_i,
    // raw source lines towards the controller
    output logic [31:0] src_line_o
);
    // a level cause stays up until the handler itself removes it
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            src_line_o <= 32'h0;
        end
        else
        begin
            src_line_o <= level_req_i;
        end
    end
endmodule // core_side_model
`default_nettype wire

// ### tb/vectored_interrupt_command_unit_test.sv
`timescale 1ns/1ns
`default_nettype none
module vectored_interrupt_command_unit_test;
    import vic_cmd_pkg::*;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] level_req = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] src_line;
    logic fast_n;
    logic normal_n;
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] vec [32];
    logic [31:0] rd;
    logic [31:0] r;
    logic [31:0] d;
    logic err;

    initial
    begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    vic_cmd_unit uut (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .src_line_i(src_line),
        .fast_request_line_n_o(fast_n), .normal_request_line_n_o(normal_n));

    core_side_model partner (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .level_req_i(level_req),
        .src_line_o(src_line));

    function automatic logic [31:0] mode_w(input logic [1:0] trig, input logic [2:0] prio);
        return {25'h0, trig, 2'b00, prio};
    endfunction

    task automatic conclude();
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            chk(32'h0, 32'h1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // exp is {normal active, fast active}; lines lag their cause by a few cycles
    task automatic sts(input logic [1:0] exp);
        repeat (4) @(posedge core_clk_i);
        rdchk(CORE_REQUEST_LINE_STATUS, {30'h0, exp});
        chk({30'h0, ~normal_n, ~fast_n}, {30'h0, exp});
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        num_errors++;
        conclude();
    end

    initial
    begin
        void'($urandom(92));
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        rdchk(SPURIOUS_HANDLER_ADDRESS, SPURIOUS_RESET);
        sts(2'b00);
        r = $urandom;
        wr(SPURIOUS_HANDLER_ADDRESS, r);
        rdchk(SPURIOUS_HANDLER_ADDRESS, r);
        apb(1'b0, 12'h118, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int n = 0; n < 32; n++)
        begin
            vec[n] = $urandom;
            if (VALID_SRC[n])
            begin
                wr(MODE_BASE + 12'(4 * n), mode_w(EXT_SRC[n] ? 2'b11 : 2'b01, 3'(n)));
                wr(VECT_BASE + 12'(4 * n), vec[n]);
                rdchk(MODE_BASE + 12'(4 * n), mode_w(EXT_SRC[n] ? 2'b11 : 2'b01, 3'(n)));
                rdchk(VECT_BASE + 12'(4 * n), vec[n]);
            end
        end
        wr(PENDING_CLEAR_COMMAND, 32'hffff_ffff);
        rdchk(PENDING_STATUS, 32'h0);
        repeat (4)
        begin
            r = $urandom;
            d = $urandom;
            wr(SOURCE_ENABLE_COMMAND, r);
            rdchk(MASK_STATUS, r & VALID_SRC);
            wr(SOURCE_DISABLE_COMMAND, d);
            rdchk(MASK_STATUS, r & ~d & VALID_SRC);
            wr(SOURCE_DISABLE_COMMAND, 32'hffff_ffff);
            r = $urandom;
            d = $urandom;
            wr(PENDING_SET_COMMAND, r);
            rdchk(PENDING_STATUS, r & VALID_SRC);
            wr(PENDING_CLEAR_COMMAND, d);
            rdchk(PENDING_STATUS, r & ~d & VALID_SRC);
            wr(PENDING_CLEAR_COMMAND, 32'hffff_ffff);
        end
        // nesting: priority of each source equals its low three id bits
        wr(SOURCE_ENABLE_COMMAND, 32'hffff_ffff);
        wr(PENDING_SET_COMMAND, 32'h0000_0004);
        sts(2'b10);
        rdchk(NORMAL_VECTOR_READ, vec[2]);
        rdchk(CURRENT_ID, 32'h0000_0002);
        sts(2'b00);
        rdchk(PENDING_STATUS, 32'h0);
        wr(PENDING_SET_COMMAND, 32'h0000_0050);
        sts(2'b10);
        rdchk(NORMAL_VECTOR_READ, vec[6]);
        rdchk(CURRENT_ID, 32'h0000_0006);
        sts(2'b00);
        wr(END_OF_SERVICE_COMMAND, $urandom);
        sts(2'b10);
        rdchk(NORMAL_VECTOR_READ, vec[4]);
        wr(PENDING_SET_COMMAND, 32'h0000_0008);
        sts(2'b00);
        wr(END_OF_SERVICE_COMMAND, $urandom);
        sts(2'b10);
        rdchk(NORMAL_VECTOR_READ, vec[3]);
        repeat (2) wr(END_OF_SERVICE_COMMAND, $urandom);
        sts(2'b00);
        rdchk(NORMAL_VECTOR_READ, 32'h0);
        // fast source, edge then high level
        wr(PENDING_SET_COMMAND, 32'h0000_0001);
        sts(2'b01);
        rdchk(FAST_VECTOR_READ, vec[0]);
        sts(2'b00);
        wr(MODE_BASE, mode_w(2'b10, 3'h0));
        level_req <= 32'h0000_0001;
        sts(2'b01);
        rdchk(FAST_VECTOR_READ, vec[0]);
        sts(2'b01);
        level_req <= 32'h0;
        sts(2'b00);
        // external falling edge and low level, on lines that idle high
        wr(SOURCE_DISABLE_COMMAND, 32'h0003_0000);
        level_req <= 32'h0003_0000;
        wr(MODE_BASE + 12'h040, mode_w(2'b01, 3'h5));
        wr(MODE_BASE + 12'h044, mode_w(2'b00, 3'h6));
        wr(PENDING_CLEAR_COMMAND, 32'h0003_0000);
        rdchk(PENDING_STATUS, 32'h0);
        wr(SOURCE_ENABLE_COMMAND, 32'h0003_0000);
        level_req <= 32'h0002_0000;
        sts(2'b10);
        rdchk(PENDING_STATUS, 32'h0001_0000);
        rdchk(NORMAL_VECTOR_READ, vec[16]);
        rdchk(PENDING_STATUS, 32'h0);
        wr(END_OF_SERVICE_COMMAND, $urandom);
        level_req <= 32'h0001_0000;
        sts(2'b10);
        rdchk(NORMAL_VECTOR_READ, vec[17]);
        rdchk(PENDING_STATUS, 32'h0002_0000);
        level_req <= 32'h0003_0000;
        wr(END_OF_SERVICE_COMMAND, $urandom);
        sts(2'b00);
        rdchk(PENDING_STATUS, 32'h0);
        conclude();
    end
endmodule // vectored_interrupt_command_unit_test
`default_nettype wire
